// [design/cfg_port_pkg.sv]
// Behaviour
// RQ1 - Parallel mode: pattern pins pick live data, B5B5, FF00 or pseudo-random input
// RQ2 - B5B5 selection yields a continuous stream of alternating-bit characters
// RQ3 - Pseudo-random selection uses 1 + x^14 + x^15 regardless of scrambler
// RQ4 - Shift only while select is low, sampling data on shift-clock falling edges
// RQ5 - Every sixteenth falling edge while selected commits the word
// RQ6 - Trailing bits beyond the last full sixteen are discarded
// RQ7 - Several words may follow within one select-low period, each committed
// RQ8 - Word is eight address bits then eight data bits
// RQ9 - Controller keeps shift clock at or below 20 MHz, any duty cycle
// RQ10 - Controller initialises registers by reset pulse over 10 ns or soft reset
// RQ11 - Writing one to bit 1 of register 00h restores defaults, then self-clears
// RQ12 - During soft reset the controller holds the reset pin low
// RQ13 - Soft reset acts exactly like the hardware reset; the code reloads only ctrl_q and boost_q
// RQ14 - Bit 0 of register 00 enables readback; default zero
// RQ15 - In readback mode only writes changing the readback bit are accepted
// RQ16 - Readback mode drives addressed register data on the shared pin
// RQ17 - Controller captures readback bits on shift-clock falling edges
// RQ18 - Controller writes zero to the readback bit to resume writes
// RQ19 - Controller waits about 1 ms after supplies before reset pulse
// RQ20 - Controller waits at least 100 ns after reset before selecting
// RQ21 - Register 02 holds linearity-boost bits 6:4 and 0
// RQ22 - Serial pins form the register port only in serial mode
// RQ23 - Shift MSB first; readback bits follow the address byte
package cfg_port_pkg;
  localparam logic [7:0] ADDR_INIT_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BOOST_CTRL = 8'h02;
  localparam int READBACK_BIT = 0;
  localparam int SOFT_INIT_BIT = 1;
  localparam logic [7:0] INIT_CTRL_RESET = 8'h00;
  localparam logic [7:0] BOOST_RESET = 8'h00;
  localparam logic [7:0] BOOST_MASK = 8'h71;
  localparam int WORD_BITS = 16;
  localparam int ADDR_BITS = 8;
  localparam logic [15:0] PAT_ALT = 16'hb5b5;
  localparam logic [15:0] PAT_HALF = 16'hff00;
  localparam logic [14:0] PRBS_SEED = 15'h7fff;
  typedef enum logic [1:0] {
    SEL_LIVE = 2'b00,
    SEL_ALT = 2'b01,
    SEL_HALF = 2'b10,
    SEL_PRBS = 2'b11
  } pat_sel_t;
endpackage

// [design/cfg_port_if.sv]
`timescale 1ns/10ps
interface pat_gen_if;
  logic [1:0] sel;
  logic [15:0] live;
  logic [15:0] word;
  modport gen (input sel, input live, output word);
  modport user (output sel, output live, input word);
endinterface

// [design/pattern_gen.sv]
`timescale 1ns/10ps
module pattern_gen
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Selector path
  pat_gen_if.gen pg
);
  logic [14:0] prbs_q;
  logic [15:0] word_q;
  logic [14:0] nx;

  // ------------------------------------------------------------
  // Pseudo-random source
  // ------------------------------------------------------------
  always_comb
  begin
    nx = prbs_q;
    for (int i = 0; i < 16; i++)
    begin
      nx = {nx[13:0], nx[14] ^ nx[13]}; // see RQ3
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      prbs_q <= cfg_port_pkg::PRBS_SEED;
    end
    else
    begin
      prbs_q <= nx; // see RQ3
    end
  end

  // ------------------------------------------------------------
  // Encoder input choice
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      word_q <= 16'h0000;
    end
    else
    begin
      case (cfg_port_pkg::pat_sel_t'(pg.sel)) // see RQ1
        cfg_port_pkg::SEL_LIVE: word_q <= pg.live;
        cfg_port_pkg::SEL_ALT: word_q <= cfg_port_pkg::PAT_ALT; // see RQ2
        cfg_port_pkg::SEL_HALF: word_q <= cfg_port_pkg::PAT_HALF;
        cfg_port_pkg::SEL_PRBS: word_q <= {nx, nx[14]}; // see RQ3
        default: word_q <= pg.live;
      endcase
    end
  end

  assign pg.word = word_q;
endmodule

// [design/adc_serial_config_port.sv]
`timescale 1ns/10ps
module adc_serial_config_port
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Mode: high selects parallel-pin mode
  input wire logic parallel_mode_i,
  // Serial pins
  input wire logic serial_select_n_i,
  input wire logic shift_clk_i,
  input wire logic serial_in_pattern_sel_lo_i,
  input wire logic pattern_sel_hi_i,
  output logic readback_out_pattern_sel_hi_o,
  output logic readback_oe_o,
  // Sample path
  input wire logic [15:0] live_samples_i,
  output logic [15:0] encoder_word_o,
  // Register contents
  output logic readback_en_o,
  output logic [7:0] linearity_boost_bits_o
);
  logic [1:0] sel_n_s, sck_s, sdi_s, phi_s, par_s;
  logic sck_d1_q;
  logic [15:0] shift_q;
  logic [4:0] cnt_q;
  logic [7:0] ctrl_q;
  logic [7:0] boost_q;
  logic [7:0] rb_q;
  logic rb_drv_q;
  logic sdo_q;
  logic fall;
  logic sel;
  logic commit;
  logic [15:0] word;
  logic init;
  logic [7:0] rd_data;
  pat_gen_if pgi ();

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sel_n_s <= 2'b11;
      sck_s <= 2'b00;
      sdi_s <= 2'b00;
      phi_s <= 2'b00;
      par_s <= 2'b00;
      sck_d1_q <= 1'b0;
    end
    else
    begin
      sel_n_s <= {sel_n_s[0], serial_select_n_i};
      sck_s <= {sck_s[0], shift_clk_i};
      sdi_s <= {sdi_s[0], serial_in_pattern_sel_lo_i};
      phi_s <= {phi_s[0], pattern_sel_hi_i};
      par_s <= {par_s[0], parallel_mode_i};
      sck_d1_q <= sck_s[1];
    end
  end

  assign fall = sck_d1_q & ~sck_s[1];
  assign sel = ~sel_n_s[1] & ~par_s[1]; // see RQ22 RQ4
  assign word = {shift_q[14:0], sdi_s[1]}; // see RQ23 RQ8
  assign commit = sel & fall & (cnt_q == 5'(cfg_port_pkg::WORD_BITS - 1));

  // ------------------------------------------------------------
  // Shift register and bit counter
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (srst_i || !sel)
    begin
      cnt_q <= 5'd0; // see RQ6
      shift_q <= 16'h0000;
    end
    else if (fall)
    begin
      shift_q <= word; // see RQ4
      cnt_q <= commit ? 5'd0 : cnt_q + 5'd1; // see RQ5 RQ7
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  assign init = commit && (word[15:8] == cfg_port_pkg::ADDR_INIT_CTRL)
    && word[cfg_port_pkg::SOFT_INIT_BIT]
    && !ctrl_q[cfg_port_pkg::READBACK_BIT];

  always_ff @(posedge clk_i)
  begin
    if (srst_i || init) // see RQ11 RQ13
    begin
      ctrl_q <= cfg_port_pkg::INIT_CTRL_RESET;
      boost_q <= cfg_port_pkg::BOOST_RESET;
    end
    else if (commit)
    begin
      if (word[15:8] == cfg_port_pkg::ADDR_INIT_CTRL)
      begin
        ctrl_q[cfg_port_pkg::READBACK_BIT] <=
          word[cfg_port_pkg::READBACK_BIT]; // see RQ14 RQ15
      end
      else if (word[15:8] == cfg_port_pkg::ADDR_BOOST_CTRL
        && !ctrl_q[cfg_port_pkg::READBACK_BIT]) // see RQ15
      begin
        boost_q <= word[7:0] & cfg_port_pkg::BOOST_MASK; // see RQ21
      end
    end
  end

  // ------------------------------------------------------------
  // Readback
  // ------------------------------------------------------------
  always_comb
  begin
    case ({shift_q[6:0], sdi_s[1]})
      cfg_port_pkg::ADDR_INIT_CTRL: rd_data = ctrl_q;
      cfg_port_pkg::ADDR_BOOST_CTRL: rd_data = boost_q;
      default: rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i || !sel)
    begin
      rb_q <= 8'h00;
      rb_drv_q <= 1'b0;
      sdo_q <= 1'b0;
    end
    else if (fall && ctrl_q[cfg_port_pkg::READBACK_BIT])
    begin
      if (cnt_q == 5'(cfg_port_pkg::ADDR_BITS - 1))
      begin
        rb_q <= {rd_data[6:0], 1'b0}; // see RQ16 RQ23
        sdo_q <= rd_data[7];
        rb_drv_q <= 1'b1;
      end
      else if (commit)
      begin
        rb_drv_q <= 1'b0;
        sdo_q <= 1'b0;
      end
      else if (rb_drv_q)
      begin
        sdo_q <= rb_q[7]; // see RQ17
        rb_q <= {rb_q[6:0], 1'b0};
      end
    end
  end

  // ------------------------------------------------------------
  // Test pattern path
  // ------------------------------------------------------------
  assign pgi.sel = par_s[1] ? {phi_s[1], sdi_s[1]}
    : cfg_port_pkg::SEL_LIVE; // see RQ1 RQ22
  assign pgi.live = live_samples_i;

  pattern_gen u_pat
  (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .pg(pgi)
  );

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign readback_out_pattern_sel_hi_o = sdo_q;
  assign readback_oe_o = rb_drv_q;
  assign encoder_word_o = pgi.word;
  assign readback_en_o = ctrl_q[cfg_port_pkg::READBACK_BIT];
  assign linearity_boost_bits_o = boost_q;
endmodule

// [verif/cfg_port_asserts.sv]
`timescale 1ns/10ps
module cfg_port_asserts
(
  // Watched ports
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic parallel_mode_i,
  input wire logic serial_select_n_i,
  input wire logic serial_in_pattern_sel_lo_i,
  input wire logic pattern_sel_hi_i,
  input wire logic [15:0] live_samples_i,
  input wire logic readback_oe_o,
  input wire logic [15:0] encoder_word_o,
  input wire logic readback_en_o,
  input wire logic [7:0] linearity_boost_bits_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  sequence s_pins(logic h, logic l);
    (parallel_mode_i && pattern_sel_hi_i == h &&
      serial_in_pattern_sel_lo_i == l)[*8];
  endsequence
  sequence s_serial;
    (!parallel_mode_i)[*8];
  endsequence
  a_reset_defaults: assert property (
    $fell(srst_i) |-> !readback_en_o && !readback_oe_o &&
      linearity_boost_bits_o == 8'h00)
    else $error("outputs not cleared by reset");
  a_boost_mask: assert property (
    (linearity_boost_bits_o & 8'h8e) == 8'h00)
    else $error("boost register holds unused bits");
  a_oe_needs_en: assert property (
    readback_oe_o |-> readback_en_o || $past(readback_en_o))
    else $error("readback driven outside readback mode");
  a_live_path: assert property (
    s_serial |-> encoder_word_o == $past(live_samples_i) ||
      encoder_word_o == $past(live_samples_i, 2))
    else $error("encoder word not live samples");
  a_alt_word: assert property (
    s_pins(1'b0, 1'b1) |-> encoder_word_o == cfg_port_pkg::PAT_ALT)
    else $error("alternating word missing");
  a_half_word: assert property (
    s_pins(1'b1, 1'b0) |-> encoder_word_o == cfg_port_pkg::PAT_HALF)
    else $error("half word missing");
  a_prbs_runs: assert property (
    s_pins(1'b1, 1'b1) |-> encoder_word_o != $past(encoder_word_o))
    else $error("pseudo-random word stuck");
  a_write_cause: assert property (
    $changed({readback_en_o, linearity_boost_bits_o}) |->
      !$past(serial_select_n_i, 5))
    else $error("register changed without select");
  a_locked_writes: assert property (
    $past(readback_en_o) |-> $stable(linearity_boost_bits_o))
    else $error("write accepted in readback mode");
endmodule
bind adc_serial_config_port cfg_port_asserts chk (.clk_i(clk_i),
  .srst_i(srst_i), .parallel_mode_i(parallel_mode_i),
  .serial_select_n_i(serial_select_n_i),
  .serial_in_pattern_sel_lo_i(serial_in_pattern_sel_lo_i),
  .pattern_sel_hi_i(pattern_sel_hi_i), .live_samples_i(live_samples_i),
  .readback_oe_o(readback_oe_o), .encoder_word_o(encoder_word_o),
  .readback_en_o(readback_en_o),
  .linearity_boost_bits_o(linearity_boost_bits_o));

// [verif/serial_host.sv]
`timescale 1ns/10ps
module serial_host
(
  // Clock and readback pin
  input wire logic clk_i,
  input wire logic rb_i,
  // Serial pins
  output logic sel_n_o,
  output logic sclk_o,
  output logic sd_o
);
  initial
  begin
    sel_n_o = 1'b1;
    sclk_o = 1'b1;
    sd_o = 1'b0;
  end
  // Released data line shows the inverse of its last bit
  task select(input logic v);
    @(negedge clk_i);
    if (v)
      sd_o = ~sd_o;
    sel_n_o = v;
    repeat (4) @(negedge clk_i);
  endtask
  // MSB first, 320 ns shift period, readback taken at falls
  task shift(input logic [15:0] w, input int n, output logic [7:0] rd);
    for (int i = 15; i > 15 - n; i--)
    begin
      sd_o = w[i];
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b0;
      rd = {rd[6:0], rb_i};
      repeat (4) @(negedge clk_i);
      sclk_o = 1'b1;
    end
    repeat (4) @(negedge clk_i);
  endtask
endmodule

// [verif/adc_serial_config_port_tb.sv]
`timescale 1ns/10ps
module adc_serial_config_port_tb;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic par = 1'b0;
  logic hi = 1'b0;
  logic [15:0] live = 16'h1234;
  logic sel_n, sclk, sd, rb, oe, rben;
  logic [15:0] enc, prev;
  logic [7:0] boost, rd;
  int fails = 0;
  int total_checks = 0;
  always #20 clk_i = ~clk_i;
  serial_host host (.clk_i(clk_i), .rb_i(rb), .sel_n_o(sel_n),
    .sclk_o(sclk), .sd_o(sd));
  adc_serial_config_port DUT (.clk_i(clk_i), .srst_i(srst_i),
    .parallel_mode_i(par), .serial_select_n_i(sel_n), .shift_clk_i(sclk),
    .serial_in_pattern_sel_lo_i(sd), .pattern_sel_hi_i(hi),
    .readback_out_pattern_sel_hi_o(rb), .readback_oe_o(oe),
    .live_samples_i(live), .encoder_word_o(enc), .readback_en_o(rben),
    .linearity_boost_bits_o(boost));
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task word(input logic [15:0] w);
    host.select(1'b0);
    host.shift(w, 16, rd);
    host.select(1'b1);
  endtask
  task t_writes;
    host.select(1'b0);
    host.shift(16'h02ff, 16, rd);
    chk({8'h00, boost}, 16'h0071);
    host.shift(16'h0255, 16, rd);
    chk({8'h00, boost}, 16'h0051);
    host.shift(16'h02ff, 15, rd);
    host.select(1'b1);
    chk({8'h00, boost}, 16'h0051);
    $display("writes done");
  endtask
  task t_readback;
    word(16'h0001);
    chk({15'h0000, rben}, 16'h0001);
    word(16'h0200);
    chk({8'h00, rd}, 16'h0051);
    chk({8'h00, boost}, 16'h0051);
    chk({15'h0000, oe}, 16'h0000);
    word(16'h0003);
    chk({8'h00, rd}, 16'h0001);
    word(16'h0000);
    chk({15'h0000, rben}, 16'h0000);
    $display("readback done");
  endtask
  task t_soft_init;
    word(16'h0002);
    chk({7'h00, rben, boost}, 16'h0000);
    word(16'h0001);
    word(16'h0001);
    chk({8'h00, rd}, 16'h0001);
    word(16'h0000);
    $display("soft init done");
  endtask
  task t_patterns;
    logic [15:0] exp [4];
    exp = '{live, cfg_port_pkg::PAT_ALT, cfg_port_pkg::PAT_HALF, 16'h0000};
    par = 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      hi = c[1];
      host.sd_o = c[0];
      repeat (10) @(negedge clk_i);
      prev = enc;
      @(negedge clk_i);
      if (c < 3)
        chk(enc, exp[c]);
      else
        chk({15'h0000, enc !== prev}, 16'h0001);
    end
    par = 1'b0;
    hi = 1'b0;
    $display("patterns done");
  endtask
  initial
  begin
    repeat (10) @(negedge clk_i);
    srst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk({7'h00, rben, boost}, 16'h0000);
    t_writes;
    t_readback;
    t_soft_init;
    t_patterns;
    summarize;
  end
  initial
  begin
    #400000;
    fails++;
    summarize;
  end
endmodule
